// *** test/pcsm_core_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcsm_core_properties
   import pcsm_pkg::*;
#(
   parameter int AW = IMPL_AW
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Watched inputs
   input wire pcsm_op_e op_i,
   input wire logic jump_i,
   input wire logic [PC_W-1:0] jump_addr_i,
   input wire logic irq_i,
   input wire logic stall_i,
   input wire pcsm_context_s context_i,
   input wire logic stack_reset_en_i,
   input wire logic flags_clear_i,
   input wire logic fp_wr_i,
   input wire logic fp_sel_i,
   input wire logic [FP_W-1:0] fp_wdata_i,
   input wire logic ind_rd_i,
   input wire logic ind_wr_i,
   input wire logic ind_sel_i,
   // Watched outputs
   input wire logic [$bits(pcsm_context_s)-1:0] context_o,
   input wire logic context_restore_o,
   input wire logic stack_overflow_flag_o,
   input wire logic stack_underflow_flag_o,
   input wire logic soft_reset_o,
   input wire logic ind_valid_o,
   input wire logic ind_busy_o,
   input wire logic data_rd_o,
   input wire logic data_wr_o,
   input wire logic [PC_W-1:0] pc_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ---------
   // Pointer mirror
   // ---------
   // A restore on RETFIE is not followed: keep pointers unchanged across it
   logic [FP_W-1:0] fp_m [2];
   logic prog_sel;
   logic go;
   assign prog_sel = fp_m[ind_sel_i][FP_PROG_BIT];
   assign go = !stall_i && !soft_reset_o;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fp_m[0] <= FP_RESET;
         fp_m[1] <= FP_RESET;
      end else if (fp_wr_i) begin
         fp_m[fp_sel_i] <= fp_wdata_i;
      end
   end
   sequence s_prog_wait;
      ind_busy_o ##1 (ind_valid_o && !ind_busy_o);
   endsequence
   sequence s_data_read;
      (data_rd_o && !ind_busy_o) ##1 ind_valid_o;
   endsequence
   // ---------
   // Assertions
   // ---------
   a_irq_vector: assert property (
      go && irq_i |=> pc_o == INT_VECTOR) else $error("bad irq vector");
   a_call_target: assert property (
      go && !irq_i && op_i == PCSM_OP_CALL && jump_i
      |=> pc_o == ($past(jump_addr_i) & {4'h0, LAST_ADDR}))
      else $error("bad call target");
   a_pc_wrap: assert property (
      (pc_o >> AW) == '0) else $error("pc outside space");
   a_stall_hold: assert property (
      stall_i && !soft_reset_o |=> $stable(pc_o)) else $error("pc moved");
   a_irq_shadow: assert property (
      go && irq_i |=> context_o == $past(context_i))
      else $error("shadow not saved");
   a_retfie_restore: assert property (
      go && !irq_i && op_i == PCSM_OP_RETFIE |=> context_restore_o)
      else $error("no restore");
   a_prog_read: assert property (
      ind_rd_i && prog_sel |=> s_prog_wait) else $error("bad program read");
   a_data_read: assert property (
      ind_rd_i && !prog_sel |=> s_data_read) else $error("bad data read");
   a_prog_write: assert property (
      ind_wr_i && prog_sel |=> ind_valid_o && !data_wr_o)
      else $error("program write leaked");
   a_flags_clear: assert property (
      flags_clear_i && !irq_i && op_i == PCSM_OP_NONE
      |=> !stack_overflow_flag_o && !stack_underflow_flag_o)
      else $error("flags not cleared");
   a_flag_sticky: assert property (
      stack_overflow_flag_o && !flags_clear_i |=> stack_overflow_flag_o)
      else $error("flag dropped");
   a_error_reset: assert property (
      ($rose(stack_overflow_flag_o) || $rose(stack_underflow_flag_o))
      && stack_reset_en_i |-> ##[0:2] soft_reset_o)
      else $error("no soft reset");
   a_soft_reset_pc: assert property (
      soft_reset_o |=> pc_o == RESET_VECTOR) else $error("pc not cleared");
endmodule // pcsm_core_properties

bind pcsm_core pcsm_core_properties #(.AW(AW)) u_props (
   .clock_i(clock_i), .rst_i(rst_i), .op_i(op_i), .jump_i(jump_i),
   .jump_addr_i(jump_addr_i), .irq_i(irq_i), .stall_i(stall_i),
   .context_i(context_i), .stack_reset_en_i(stack_reset_en_i),
   .flags_clear_i(flags_clear_i), .fp_wr_i(fp_wr_i), .fp_sel_i(fp_sel_i),
   .fp_wdata_i(fp_wdata_i), .ind_rd_i(ind_rd_i), .ind_wr_i(ind_wr_i),
   .ind_sel_i(ind_sel_i), .context_o(context_o),
   .context_restore_o(context_restore_o),
   .stack_overflow_flag_o(stack_overflow_flag_o),
   .stack_underflow_flag_o(stack_underflow_flag_o),
   .soft_reset_o(soft_reset_o), .ind_valid_o(ind_valid_o),
   .ind_busy_o(ind_busy_o), .data_rd_o(data_rd_o), .data_wr_o(data_wr_o),
   .pc_o(pc_o));
`default_nettype wire

// *** test/pcsm_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import pcsm_pkg::*;
   // ---------
   // Signals
   // ---------
   logic clock_i, rst_i, jump_i, irq_i, stall_i, stack_reset_en_i;
   logic flags_clear_i, fp_wr_i, fp_sel_i, ind_rd_i, ind_wr_i, ind_sel_i;
   logic context_restore_o, stack_overflow_flag_o, stack_underflow_flag_o;
   logic soft_reset_o, ind_valid_o, ind_busy_o, ind_hef_o, data_rd_o;
   logic data_wr_o, load_i;
   pcsm_op_e op_i;
   pcsm_context_s context_i;
   logic [$bits(pcsm_context_s)-1:0] context_o;
   logic [PC_W-1:0] jump_addr_i, pc_o, load_addr_i;
   logic [WORD_W-1:0] instr_o, load_word_i;
   logic [FP_W-1:0] fp_wdata_i;
   logic [7:0] ind_wdata_i, ind_rdata_o, data_wdata_o, data_rdata_i;
   logic [11:0] data_addr_o;
   int err_total, samples_checked;

   pcsm_core dut (.clock_i, .rst_i, .op_i, .jump_i, .jump_addr_i, .irq_i,
      .stall_i, .context_i, .context_o, .context_restore_o,
      .stack_reset_en_i, .flags_clear_i, .stack_overflow_flag_o,
      .stack_underflow_flag_o, .soft_reset_o, .fp_wr_i, .fp_sel_i,
      .fp_wdata_i, .ind_rd_i, .ind_wr_i, .ind_sel_i, .ind_wdata_i,
      .ind_rdata_o, .ind_valid_o, .ind_busy_o, .ind_hef_o, .data_addr_o,
      .data_rd_o, .data_wr_o, .data_wdata_o, .data_rdata_i, .pc_o,
      .instr_o, .load_i, .load_addr_i, .load_word_i);

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   // ---------
   // Shared tasks
   // ---------
   task automatic tick();
      @(negedge clock_i);
   endtask
   task automatic chk(input bit ok, input string m);
      samples_checked++;
      if (!ok) begin
         $display("wrong value at %0t ns: %s", $time, m);
         err_total++;
      end
   endtask
   task automatic results();
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst_i = 1'b1;
      repeat (6) tick();
      rst_i = 1'b0;
   endtask
   task automatic go(input pcsm_op_e op, input logic j, input logic q,
      input logic [14:0] a);
      op_i = op;
      jump_i = j;
      irq_i = q;
      jump_addr_i = a;
      tick();
   endtask
   // Ends one idle cycle later so back-to-back calls never collide
   task automatic set_fp(input logic s, input logic [15:0] v);
      fp_wr_i = 1'b1;
      fp_sel_i = s;
      fp_wdata_i = v;
      tick();
      fp_wr_i = 1'b0;
      tick();
   endtask
   task automatic access(input logic w, input logic s);
      ind_rd_i = !w;
      ind_wr_i = w;
      ind_sel_i = s;
      tick();
      ind_rd_i = 1'b0;
      ind_wr_i = 1'b0;
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_call_return();
      logic [14:0] t;
      go(PCSM_OP_NONE, 1'b1, 1'b0, 15'h0100);
      stall_i = 1'b1;
      go(PCSM_OP_CALL, 1'b0, 1'b0, 15'h0300);
      stall_i = 1'b0;
      chk(pc_o === 15'h0100, "stall moved pc");
      for (int k = 0; k < 16; k++) begin
         go(PCSM_OP_CALL, 1'b1, 1'b0, 15'h7800 + 15'(k * 16 + 1));
         chk(pc_o === 15'(k * 16 + 1), "call target");
      end
      chk(stack_overflow_flag_o === 1'b0, "overflow at 16");
      for (int k = 15; k >= 0; k--) begin
         go(PCSM_OP_RETURN, 1'b0, 1'b0, 15'h0000);
         t = (k == 0) ? 15'h0100 : 15'((k - 1) * 16 + 1);
         chk(pc_o === t, "return address");
      end
      chk(stack_underflow_flag_o === 1'b0, "early underflow");
      go(PCSM_OP_RETURN, 1'b0, 1'b0, 15'h0000);
      go(PCSM_OP_NONE, 1'b0, 1'b0, 15'h0000);
      chk(stack_underflow_flag_o === 1'b1, "underflow");
      chk(soft_reset_o === 1'b0, "reset while disabled");
      flags_clear_i = 1'b1;
      tick();
      flags_clear_i = 1'b0;
      chk(stack_underflow_flag_o === 1'b0, "flag clear");
   endtask
   task automatic t_irq();
      pcsm_context_s c;
      c = {8'h5a, 8'h03, 8'h1f, 8'h07, 32'h0};
      go(PCSM_OP_NONE, 1'b1, 1'b0, 15'h0200);
      context_i = c;
      go(PCSM_OP_NONE, 1'b0, 1'b1, 15'h0000);
      context_i = ~c;
      chk(pc_o === INT_VECTOR, "irq vector");
      chk(context_o === c, "shadow save");
      go(PCSM_OP_RETFIE, 1'b0, 1'b0, 15'h0000);
      chk(pc_o === 15'h0200, "retfie address");
      chk(context_restore_o === 1'b1 && context_o === c, "restore");
      go(PCSM_OP_NONE, 1'b0, 1'b0, 15'h0000);
   endtask
   task automatic t_indirect();
      load_i = 1'b1;
      load_addr_i = 15'h0010;
      load_word_i = 14'h1234;
      tick();
      load_addr_i = 15'h0790;
      load_word_i = 14'h2a5b;
      tick();
      load_i = 1'b0;
      go(PCSM_OP_NONE, 1'b1, 1'b0, 15'h4010);
      chk(pc_o === 15'h0010 && instr_o === 14'h1234, "fetch wrap");
      set_fp(1'b0, 16'h2055);
      set_fp(1'b1, 16'h8790);
      access(1'b0, 1'b0);
      chk(data_rd_o === 1'b1 && data_addr_o === 12'h0a5, "linear");
      tick();
      chk(ind_valid_o === 1'b1 && ind_rdata_o === 8'h3c, "data rd");
      ind_wdata_i = 8'h96;
      access(1'b1, 1'b0);
      chk(data_wr_o === 1'b1 && data_wdata_o === 8'h96, "data wr");
      tick();
      access(1'b1, 1'b1);
      chk(ind_valid_o === 1'b1 && data_wr_o === 1'b0, "prog wr");
      tick();
      access(1'b0, 1'b1);
      chk(ind_busy_o === 1'b1 && ind_valid_o === 1'b0, "wait");
      tick();
      chk(ind_valid_o === 1'b1 && ind_rdata_o === 8'h5b, "prog rd");
      chk(ind_hef_o === 1'b1, "hef region");
      set_fp(1'b1, 16'h8810);
      access(1'b0, 1'b1);
      tick();
      chk(ind_rdata_o === 8'h34 && ind_hef_o === 1'b0, "wrap rd");
   endtask
   task automatic t_overflow();
      int n;
      do_reset();
      stack_reset_en_i = 1'b1;
      for (int k = 0; k < 17; k++) begin
         go(PCSM_OP_CALL, 1'b0, 1'b0, 15'(k + 8));
      end
      chk(stack_overflow_flag_o === 1'b1, "overflow");
      n = 0;
      while (soft_reset_o !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      if (n == 4) begin
         chk(1'b0, "soft reset timeout");
         results();
      end
      go(PCSM_OP_NONE, 1'b0, 1'b0, 15'h0000);
      chk(pc_o === RESET_VECTOR, "pc after soft reset");
   endtask
   // ---------
   // Main sequence
   // ---------
   initial begin
      {jump_i, irq_i, stall_i, stack_reset_en_i, flags_clear_i} = '0;
      {fp_wr_i, fp_sel_i, ind_rd_i, ind_wr_i, ind_sel_i, load_i} = '0;
      {jump_addr_i, load_addr_i, load_word_i, fp_wdata_i} = '0;
      op_i = PCSM_OP_NONE;
      context_i = '0;
      ind_wdata_i = 8'h00;
      data_rdata_i = 8'h3c;
      err_total = 0;
      samples_checked = 0;
      do_reset();
      chk(pc_o === RESET_VECTOR, "reset pc");
      t_call_return();
      t_irq();
      t_indirect();
      t_overflow();
      results();
   end
endmodule // testbench
`default_nettype wire

// *** verilog/pcsm_core.sv ***
// Functional notes
// - Return stack holds sixteen 15-bit return addresses.
// - Push past full sets overflow flag; pop on empty sets underflow flag.
// - With stack reset option on, either stack error requests a reset.
// - Indirect reads of program memory take one extra cycle.
// - Program counter is 15 bits over a 32K by 14 space.
// - Addresses above 2,048 words wrap into the implemented space.
// - Reset starts at 0000h; interrupt entry jumps to 0004h.
// - Words 0780h to 07FFh low bytes form the high-endurance region.
// - Interrupt entry saves context to shadows; return restores it.
// - Two 16-bit file pointers reach data and program memory.
// - Pointers address general RAM as one linear region.
// - Pointer bit 15 selects program memory; reads return low byte.
// - Indirect writes to program memory are ignored.
`timescale 1ns/1ns
`default_nettype none
module pcsm_core
   import pcsm_pkg::*;
#(
   parameter int AW = IMPL_AW
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Flow control from the instruction decoder
   input wire pcsm_op_e op_i,
   input wire logic jump_i,
   input wire logic [PC_W-1:0] jump_addr_i,
   input wire logic irq_i,
   input wire logic stall_i,
   // Context exchanged with the core registers
   input wire pcsm_context_s context_i,
   output logic [$bits(pcsm_context_s)-1:0] context_o,
   output logic context_restore_o,
   // Stack control and status
   input wire logic stack_reset_en_i,
   input wire logic flags_clear_i,
   output logic stack_overflow_flag_o,
   output logic stack_underflow_flag_o,
   output logic soft_reset_o,
   // File pointer writes
   input wire logic fp_wr_i,
   input wire logic fp_sel_i,
   input wire logic [FP_W-1:0] fp_wdata_i,
   // Indirect data port
   input wire logic ind_rd_i,
   input wire logic ind_wr_i,
   input wire logic ind_sel_i,
   input wire logic [7:0] ind_wdata_i,
   output logic [7:0] ind_rdata_o,
   output logic ind_valid_o,
   output logic ind_busy_o,
   output logic ind_hef_o,
   output logic [11:0] data_addr_o,
   output logic data_rd_o,
   output logic data_wr_o,
   output logic [7:0] data_wdata_o,
   input wire logic [7:0] data_rdata_i,
   // Fetch
   output logic [PC_W-1:0] pc_o,
   output logic [WORD_W-1:0] instr_o,
   // Program load
   input wire logic load_i,
   input wire logic [PC_W-1:0] load_addr_i,
   input wire logic [WORD_W-1:0] load_word_i
);
   typedef enum {PCSM_IDLE, PCSM_PROG_WAIT} pcsm_ind_e;

   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [FP_W-1:0] fp [2];
   logic [FP_W-1:0] next_fp0;
   logic [FP_W-1:0] next_fp1;
   pcsm_context_s shadow;
   pcsm_context_s next_shadow;
   logic restore;
   logic next_restore;
   pcsm_stack_flags_s flags;
   pcsm_stack_flags_s next_flags;
   logic soft_reset;
   logic next_soft_reset;
   pcsm_ind_e ind_state;
   pcsm_ind_e next_ind_state;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic valid;
   logic next_valid;
   logic high_endurance_region;
   logic next_hef;
   logic busy;
   logic next_busy;
   logic [11:0] daddr;
   logic [11:0] next_daddr;
   logic drd;
   logic next_drd;
   logic dwr;
   logic next_dwr;
   logic [7:0] dwdata;
   logic [7:0] next_dwdata;
   logic push;
   logic pop;
   logic [PC_W-1:0] stack_top;
   logic st_ovf;
   logic st_unf;
   logic [FP_W-1:0] sel_ptr;
   logic [PC_W-1:0] prog_addr;
   logic [WORD_W-1:0] prog_word;
   logic prog_hef;
   logic irq_take;

   // Wrap any address into the implemented words
   function automatic logic [PC_W-1:0] pcsm_wrap(input logic [PC_W-1:0] a);
      pcsm_wrap = {{(PC_W-AW){1'b0}}, a[AW-1:0]};
   endfunction

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   pcsm_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .push_i(push),
      .pop_i(pop),
      .push_data_i(pc),
      .top_o(stack_top),
      .overflow_o(st_ovf),
      .underflow_o(st_unf)
   );

   pcsm_pmem #(.AW(AW)) u_pmem (
      .clock_i(clock_i),
      .fetch_addr_i(next_pc),
      .fetch_word_o(instr_o),
      .data_addr_i(prog_addr),
      .data_word_o(prog_word),
      .data_hef_o(prog_hef),
      .load_i(load_i),
      .load_addr_i(load_addr_i),
      .load_word_i(load_word_i)
   );

   // ------------------------------------------------------------
   // Program counter and stack
   // ------------------------------------------------------------
   assign irq_take = irq_i && !stall_i;
   assign push = !stall_i && (irq_take || op_i == PCSM_OP_CALL);
   assign pop = !stall_i && !irq_i
      && (op_i == PCSM_OP_RETURN || op_i == PCSM_OP_RETFIE);

   always_comb begin
      next_pc = pc;
      next_restore = 1'b0;
      next_shadow = shadow;
      if (rst_i || soft_reset) begin
         next_pc = RESET_VECTOR;
      end else if (!stall_i) begin
         if (irq_take) begin
            next_pc = INT_VECTOR;
            next_shadow = context_i;
         end else if (pop) begin
            next_pc = pcsm_wrap(stack_top);
            next_restore = (op_i == PCSM_OP_RETFIE);
         end else if (jump_i) begin
            next_pc = pcsm_wrap(jump_addr_i);
         end else begin
            next_pc = pcsm_wrap(PC_W'(pc + 15'h0001));
         end
      end
   end

   // Set wins over software clear so no error is lost
   always_comb begin
      next_flags = flags;
      if (flags_clear_i) begin
         next_flags = '0;
      end
      if (st_ovf) begin
         next_flags.overflow = 1'b1;
      end
      if (st_unf) begin
         next_flags.underflow = 1'b1;
      end
      next_soft_reset = stack_reset_en_i && (st_ovf || st_unf);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pc <= RESET_VECTOR;
         shadow <= '0;
         restore <= 1'b0;
         flags <= '0;
         soft_reset <= 1'b0;
      end else begin
         pc <= next_pc;
         shadow <= next_shadow;
         restore <= next_restore;
         flags <= next_flags;
         soft_reset <= next_soft_reset;
      end
   end

   // ------------------------------------------------------------
   // File pointers and indirect port
   // ------------------------------------------------------------
   assign sel_ptr = fp[ind_sel_i];
   assign prog_addr = PC_W'(sel_ptr[PC_W-1:0]);

   always_comb begin
      next_fp0 = fp[0];
      next_fp1 = fp[1];
      if (restore) begin
         next_fp0 = shadow.fp0;
         next_fp1 = shadow.fp1;
      end else if (fp_wr_i) begin
         if (fp_sel_i) begin
            next_fp1 = fp_wdata_i;
         end else begin
            next_fp0 = fp_wdata_i;
         end
      end
   end

   always_comb begin
      next_ind_state = ind_state;
      next_rdata = rdata;
      next_valid = 1'b0;
      next_hef = high_endurance_region;
      next_daddr = daddr;
      next_drd = 1'b0;
      next_dwr = 1'b0;
      next_dwdata = dwdata;
      case (ind_state)
         PCSM_IDLE: begin
            if (ind_rd_i && sel_ptr[FP_PROG_BIT]) begin
               next_ind_state = PCSM_PROG_WAIT;
            end else if (ind_rd_i || ind_wr_i) begin
               if (!sel_ptr[FP_PROG_BIT]) begin
                  if (sel_ptr >= LINEAR_BASE && sel_ptr <= LINEAR_TOP) begin
                     next_daddr = pcsm_linear_to_banked(sel_ptr);
                  end else begin
                     next_daddr = sel_ptr[11:0];
                  end
                  next_drd = ind_rd_i;
                  next_dwr = ind_wr_i;
                  next_dwdata = ind_wdata_i;
               end
               // Writes aimed at program memory are dropped
               next_valid = ind_wr_i;
            end
         end
         PCSM_PROG_WAIT: begin
            next_rdata = prog_word[7:0];
            next_hef = prog_hef;
            next_valid = 1'b1;
            next_ind_state = PCSM_IDLE;
         end
         default: begin
            next_ind_state = PCSM_IDLE;
         end
      endcase
      if (drd) begin
         next_rdata = data_rdata_i;
         next_hef = 1'b0;
         next_valid = 1'b1;
      end
      // Registered copy so the busy pin comes straight from a flop
      next_busy = (next_ind_state == PCSM_PROG_WAIT);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fp[0] <= FP_RESET;
         fp[1] <= FP_RESET;
         ind_state <= PCSM_IDLE;
         rdata <= 8'h00;
         valid <= 1'b0;
         high_endurance_region <= 1'b0;
         busy <= 1'b0;
         daddr <= 12'h000;
         drd <= 1'b0;
         dwr <= 1'b0;
         dwdata <= 8'h00;
      end else begin
         fp[0] <= next_fp0;
         fp[1] <= next_fp1;
         ind_state <= next_ind_state;
         rdata <= next_rdata;
         valid <= next_valid;
         high_endurance_region <= next_hef;
         busy <= next_busy;
         daddr <= next_daddr;
         drd <= next_drd;
         dwr <= next_dwr;
         dwdata <= next_dwdata;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign pc_o = pc;
   assign context_o = shadow;
   assign context_restore_o = restore;
   assign stack_overflow_flag_o = flags.overflow;
   assign stack_underflow_flag_o = flags.underflow;
   assign soft_reset_o = soft_reset;
   assign ind_rdata_o = rdata;
   assign ind_valid_o = valid;
   assign ind_busy_o = busy;
   assign ind_hef_o = high_endurance_region;
   assign data_addr_o = daddr;
   assign data_rd_o = drd;
   assign data_wr_o = dwr;
   assign data_wdata_o = dwdata;
endmodule // pcsm_core
`default_nettype wire

// *** verilog/pcsm_pkg.sv ***
`default_nettype none
package pcsm_pkg;
   // ------------------------------------------------------------
   // Program space
   // ------------------------------------------------------------
   localparam int PC_W = 15;
   localparam int WORD_W = 14;
   localparam int IMPL_AW = 11;
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] INT_VECTOR = 15'h0004;
   localparam logic [10:0] LAST_ADDR = 11'h7ff;
   localparam logic [10:0] HEF_FIRST = 11'h780;
   localparam logic [10:0] HEF_LAST = 11'h7ff;
   // ------------------------------------------------------------
   // Stack
   // ------------------------------------------------------------
   localparam int STACK_DEPTH = 16;
   localparam int STACK_PTR_W = 5;
   // ------------------------------------------------------------
   // File pointers
   // ------------------------------------------------------------
   localparam int FP_W = 16;
   localparam int FP_PROG_BIT = 15;
   localparam int GPR_BANK_BYTES = 80;
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   localparam logic [15:0] LINEAR_TOP = 16'h29af;
   localparam logic [15:0] FP_RESET = 16'h0000;
   localparam int PROG_EXTRA_CYCLES = 1;

   typedef enum logic [1:0] {
      PCSM_OP_NONE,
      PCSM_OP_CALL,
      PCSM_OP_RETURN,
      PCSM_OP_RETFIE
   } pcsm_op_e;

   typedef struct packed {
      logic [7:0] wreg;
      logic [7:0] status;
      logic [7:0] bsr;
      logic [7:0] pclath;
      logic [15:0] fp0;
      logic [15:0] fp1;
   } pcsm_context_s;

   typedef struct packed {
      logic overflow;
      logic underflow;
   } pcsm_stack_flags_s;

   // Linear GPR pointer to banked data address (bank, offset)
   function automatic logic [11:0] pcsm_linear_to_banked(
      input logic [15:0] ptr
   );
      logic [11:0] off;
      logic [4:0] bank;
      off = 12'(ptr - LINEAR_BASE);
      bank = 5'(off / 12'(GPR_BANK_BYTES));
      pcsm_linear_to_banked = {bank, 7'(7'h20 + 7'(off % 12'(GPR_BANK_BYTES)))};
   endfunction
endpackage
`default_nettype wire

// *** verilog/pcsm_pmem.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcsm_pmem
   import pcsm_pkg::*;
#(
   parameter int AW = IMPL_AW
) (
   // Clock
   input wire logic clock_i,
   // Fetch port
   input wire logic [PC_W-1:0] fetch_addr_i,
   output logic [WORD_W-1:0] fetch_word_o,
   // Data read port
   input wire logic [PC_W-1:0] data_addr_i,
   output logic [WORD_W-1:0] data_word_o,
   output logic data_hef_o,
   // Load port, used by the programming path only
   input wire logic load_i,
   input wire logic [PC_W-1:0] load_addr_i,
   input wire logic [WORD_W-1:0] load_word_i
);
   logic [WORD_W-1:0] mem [2**AW];

   // Upper address bits are dropped so any address wraps
   always_ff @(posedge clock_i) begin
      if (load_i) begin
         mem[load_addr_i[AW-1:0]] <= load_word_i;
      end
      fetch_word_o <= mem[fetch_addr_i[AW-1:0]];
      data_word_o <= mem[data_addr_i[AW-1:0]];
      data_hef_o <= (data_addr_i[AW-1:0] >= HEF_FIRST)
         && (data_addr_i[AW-1:0] <= HEF_LAST);
   end
endmodule // pcsm_pmem
`default_nettype wire

// *** verilog/pcsm_stack.sv ***
`timescale 1ns/1ns
`default_nettype none
module pcsm_stack
   import pcsm_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int WIDTH = PC_W
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Operations
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [WIDTH-1:0] push_data_i,
   // Results
   output logic [WIDTH-1:0] top_o,
   output logic overflow_o,
   output logic underflow_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [STACK_PTR_W-1:0] count;
   logic [STACK_PTR_W-1:0] next_count;
   logic [3:0] wr_idx;
   logic [3:0] rd_idx;

   // ------------------------------------------------------------
   // Pointer
   // ------------------------------------------------------------
   always_comb begin
      next_count = count;
      overflow_o = 1'b0;
      underflow_o = 1'b0;
      wr_idx = count[3:0];
      rd_idx = 4'(count - 5'h01);
      if (push_i) begin
         if (count == STACK_PTR_W'(DEPTH)) begin
            overflow_o = 1'b1;
            next_count = 5'h00;
            wr_idx = 4'h0;
         end else begin
            next_count = 5'(count + 5'h01);
         end
      end else if (pop_i) begin
         if (count == 5'h00) begin
            underflow_o = 1'b1;
            rd_idx = 4'hf;
         end else begin
            next_count = 5'(count - 5'h01);
         end
      end
   end

   assign top_o = mem[rd_idx];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count <= 5'h00;
      end else begin
         count <= next_count;
      end
      if (push_i) begin
         mem[wr_idx] <= push_data_i;
      end
   end
endmodule // pcsm_stack
`default_nettype wire
